/* src/lbd_pkg.sv */
package lbd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the Avalon slave
	localparam logic [7:0] LBD_OFS_CMD = 8'h00;
	localparam logic [7:0] LBD_OFS_PTR = 8'h04;
	localparam logic [7:0] LBD_OFS_STATUS = 8'h08;
	localparam logic [7:0] LBD_OFS_CTRL = 8'h0C;
	localparam logic [1:0] LBD_OFS_BLINK_PAGE = 2'h1;
	localparam int LBD_BLINK_WORDS = 13;
	localparam int LBD_DOTS_PER_WORD = 5;
	localparam int LBD_FIFO_DEPTH = 4;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int LBD_CMD_CD_BIT = 8;
	localparam int LBD_CMD_BE_LANE = 0;
	localparam int LBD_CTRL_HOLD_BIT = 0;
	localparam int LBD_ST_ARMED = 0;
	localparam int LBD_ST_UNIT = 1;
	localparam int LBD_ST_PATTERN = 2;
	localparam int LBD_ST_OPT_DISP = 3;
	localparam int LBD_ST_OPT_BLINK = 4;
	localparam int LBD_ST_HOLD = 5;
	localparam int LBD_ST_COUNT = 8;
	localparam int LBD_OPT_DISP_BIT = 0;
	localparam int LBD_OPT_BLINK_BIT = 1;

	////////////////////////////////////////////////////////////////////////
	// Pointer values
	localparam logic [4:0] LBD_ARB_FIRST = 5'h10;
	localparam logic [4:0] LBD_ARB_LAST = 5'h1C;
	localparam logic [4:0] LBD_ARB_END = 5'h1D;
	localparam logic [4:0] LBD_PTR_STEP = 5'h01;

	////////////////////////////////////////////////////////////////////////
	// Command opcodes as mask and value on the 8-bit word
	localparam logic [7:0] LBD_UNIT_MASK = 8'hFE;
	localparam logic [7:0] LBD_UNIT_VAL = 8'h9C;
	localparam logic [7:0] LBD_ARM_MASK = 8'hFE;
	localparam logic [7:0] LBD_ARM_VAL = 8'h8C;
	localparam logic [7:0] LBD_PAT_MASK = 8'hEE;
	localparam logic [7:0] LBD_PAT_VAL = 8'h82;
	localparam logic [7:0] LBD_INC_MASK = 8'hEA;
	localparam logic [7:0] LBD_INC_VAL = 8'h8A;
	localparam logic [7:0] LBD_OPT_MASK = 8'hF0;
	localparam logic [7:0] LBD_OPT_VAL = 8'hB0;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [4:0] LBD_PTR_RST = 5'h00;
	localparam logic LBD_UNIT_RST = 1'b0;
	localparam logic LBD_PATTERN_RST = 1'b0;
	localparam logic LBD_OPT_RST = 1'b0;
	localparam logic LBD_HOLD_RST = 1'b0;
	localparam logic [31:0] LBD_RDATA_RST = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic is_ptr;
		logic cd;
		logic [7:0] data;
	} lbd_entry_type;

	localparam int LBD_ENTRY_W = $bits(lbd_entry_type);

	typedef enum logic [2:0] {
		LBD_C_DATA = 3'b000,
		LBD_C_UNIT = 3'b001,
		LBD_C_ARM = 3'b010,
		LBD_C_PATTERN = 3'b011,
		LBD_C_INC = 3'b100,
		LBD_C_OPTION = 3'b101,
		LBD_C_OTHER = 3'b110
	} lbd_cmd_type;

endpackage : lbd_pkg

/* src/lbd_fifo.sv */
`timescale 1ns/1ps
module lbd_fifo #(
	parameter int W = 10,
	parameter int D = 4,
	parameter int CW = $clog2(D + 1)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o,
	output logic [CW-1:0] count_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW-1:0] LAST = AW'(D - 1);

	logic [W-1:0] mem_r [0:D-1];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [CW-1:0] cnt_r;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == LAST) ? '0 : AW'(p + 1'b1);
	endfunction : bump

	assign in_ready_o = (cnt_r != CW'(D));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rd_r];
	assign count_o = cnt_r;
	assign push = ce_i & in_valid_i & in_ready_o;
	assign pop = ce_i & out_valid_o & out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= bump(wr_r);
			end
			if (pop) begin
				rd_r <= bump(rd_r);
			end
			if (push && !pop) begin
				cnt_r <= CW'(cnt_r + 1'b1);
			end else if (pop && !push) begin
				cnt_r <= CW'(cnt_r - 1'b1);
			end
		end
	end

endmodule : lbd_fifo

/* src/lbd_decoder.sv */
`timescale 1ns/1ps
// Contract
// - Dot blink command with arm bit one arms per-dot blink data writes.
// - Once armed, words sent with command/data low are blink data.
// - Low five bits of each blink data word stored at the pointer address.
// - Pointer advances by one after each stored blink data word.
// - Address 10H drives dots 1-5, each next address next five, 1CH dots 61-65.
// - Only 10H-1CH valid; data at 1DH dropped, pointer stays 1DH.
// - Blink pattern command decoded with its lowest bit as pattern select.
// - Select one blinks with all dots off, zero with all dots on.
// - Pattern is one global setting for all 13 characters.
// - Pointer increment command adds one to the pointer.
// - Increment applies the chosen clear action at the old pointer value.
// - Unit bit zero picks five-dot writing, one picks per-dot writing.
// - First option bit clears display entries, second clears blink entries.
module lbd_decoder
	import lbd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic pattern_o,
	output logic [LBD_BLINK_WORDS*LBD_DOTS_PER_WORD-1:0] blink_dots_o,
	output logic clear_display_o,
	output logic clear_char_blink_o,
	output logic [4:0] clear_addr_o
);
	localparam int CW = $clog2(LBD_FIFO_DEPTH + 1);

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic lbd_cmd_type decode(input logic cd, input logic [7:0] w);
		if (!cd) begin
			return LBD_C_DATA;
		end
		if ((w & LBD_UNIT_MASK) == LBD_UNIT_VAL) begin
			return LBD_C_UNIT;
		end
		if ((w & LBD_ARM_MASK) == LBD_ARM_VAL) begin
			return LBD_C_ARM;
		end
		if ((w & LBD_PAT_MASK) == LBD_PAT_VAL) begin
			return LBD_C_PATTERN;
		end
		// Loosely decoded increment is tried after the exact codes, to be safe
		if ((w & LBD_INC_MASK) == LBD_INC_VAL) begin
			return LBD_C_INC;
		end
		if ((w & LBD_OPT_MASK) == LBD_OPT_VAL) begin
			return LBD_C_OPTION;
		end
		return LBD_C_OTHER;
	endfunction : decode

	function automatic logic in_arb(input logic [4:0] p);
		return (p >= LBD_ARB_FIRST) && (p <= LBD_ARB_LAST);
	endfunction : in_arb

	function automatic logic [3:0] arb_idx(input logic [4:0] p);
		return 4'(p - LBD_ARB_FIRST);
	endfunction : arb_idx

	////////////////////////////////////////////////////////////////////////
	// Bus slave and queue
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_nxt;
	logic hold_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [LBD_ENTRY_W-1:0] fifo_out;
	logic [CW-1:0] fifo_count;
	lbd_entry_type push_entry;
	lbd_entry_type cur;
	logic is_queued;
	logic accept;
	logic wr_ok;
	logic pop;

	assign is_queued = (avs_address_i == LBD_OFS_CMD) || (avs_address_i == LBD_OFS_PTR);
	// Queued writes wait while the queue is full; that is the back-pressure
	assign accept = ce_i & wait_r & (avs_read_i | avs_write_i)
		& ~(avs_write_i & is_queued & ~fifo_in_ready);
	assign wr_ok = accept & avs_write_i & avs_byteenable_i[LBD_CMD_BE_LANE];
	assign push_entry = '{is_ptr: (avs_address_i == LBD_OFS_PTR),
		cd: avs_writedata_i[LBD_CMD_CD_BIT], data: avs_writedata_i[7:0]};
	assign cur = lbd_entry_type'(fifo_out);
	assign pop = ce_i & fifo_out_valid & ~hold_r;

	lbd_fifo #(
		.W(LBD_ENTRY_W),
		.D(LBD_FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.in_valid_i(wr_ok & is_queued),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_entry),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(~hold_r),
		.out_data_o(fifo_out),
		.count_o(fifo_count)
	);

	////////////////////////////////////////////////////////////////////////
	// Command state
	logic [4:0] ptr_r;
	logic unit_r;
	logic armed_r;
	logic pattern_r;
	logic opt_disp_r;
	logic opt_blink_r;
	logic [LBD_DOTS_PER_WORD-1:0] mem_r [0:LBD_BLINK_WORDS-1];
	logic clear_display_r;
	logic clear_char_blink_r;
	logic [4:0] clear_addr_r;
	lbd_cmd_type cmd;
	logic data_store;

	assign cmd = decode(cur.cd, cur.data);
	assign data_store = pop & ~cur.is_ptr & (cmd == LBD_C_DATA) & armed_r & in_arb(ptr_r);

	always_comb begin
		rd_nxt = '0;
		if (avs_address_i == LBD_OFS_PTR) begin
			rd_nxt[4:0] = ptr_r;
		end else if (avs_address_i == LBD_OFS_STATUS) begin
			rd_nxt[LBD_ST_ARMED] = armed_r;
			rd_nxt[LBD_ST_UNIT] = unit_r;
			rd_nxt[LBD_ST_PATTERN] = pattern_r;
			rd_nxt[LBD_ST_OPT_DISP] = opt_disp_r;
			rd_nxt[LBD_ST_OPT_BLINK] = opt_blink_r;
			rd_nxt[LBD_ST_HOLD] = hold_r;
			rd_nxt[LBD_ST_COUNT +: CW] = fifo_count;
		end else if (avs_address_i == LBD_OFS_CTRL) begin
			rd_nxt[LBD_CTRL_HOLD_BIT] = hold_r;
		end else if (avs_address_i[7:6] == LBD_OFS_BLINK_PAGE && avs_address_i[1:0] == 2'h0
			&& avs_address_i[5:2] < 4'(LBD_BLINK_WORDS)) begin
			rd_nxt[LBD_DOTS_PER_WORD-1:0] = mem_r[avs_address_i[5:2]];
		end
	end

	// One wait state per access, more for a queued write to a full queue; unmapped reads give zero, writes vanish
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_r <= 1'b1;
			rdata_r <= LBD_RDATA_RST;
		end else if (ce_i) begin
			wait_r <= ~accept;
			if (accept && avs_read_i) begin
				rdata_r <= rd_nxt;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_r <= LBD_HOLD_RST;
		end else if (wr_ok && avs_address_i == LBD_OFS_CTRL) begin
			hold_r <= avs_writedata_i[LBD_CTRL_HOLD_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_r <= LBD_PTR_RST;
		end else if (pop) begin
			if (cur.is_ptr) begin
				ptr_r <= cur.data[4:0];
			end else if (cmd == LBD_C_INC) begin
				ptr_r <= 5'(ptr_r + LBD_PTR_STEP);
			end else if (data_store) begin
				ptr_r <= 5'(ptr_r + LBD_PTR_STEP);
			end
			// Data at 1DH or any other pointer outside the range leaves it alone
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unit_r <= LBD_UNIT_RST;
			armed_r <= 1'b0;
		end else if (pop && !cur.is_ptr) begin
			if (cmd == LBD_C_UNIT) begin
				unit_r <= cur.data[0];
				armed_r <= 1'b0;
			end else if (cmd == LBD_C_ARM) begin
				// Arming needs per-dot unit, otherwise five-dot writing stays in force
				armed_r <= cur.data[0] & unit_r;
			end else if (cmd != LBD_C_DATA) begin
				// Any other command returns the link to command decoding
				armed_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pattern_r <= LBD_PATTERN_RST;
			opt_disp_r <= LBD_OPT_RST;
			opt_blink_r <= LBD_OPT_RST;
		end else if (pop && !cur.is_ptr) begin
			if (cmd == LBD_C_PATTERN) begin
				pattern_r <= cur.data[0];
			end
			if (cmd == LBD_C_OPTION) begin
				opt_disp_r <= cur.data[LBD_OPT_DISP_BIT];
				opt_blink_r <= cur.data[LBD_OPT_BLINK_BIT];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < LBD_BLINK_WORDS; i++) begin
				mem_r[i] <= '0;
			end
		end else if (data_store) begin
			mem_r[arb_idx(ptr_r)] <= cur.data[LBD_DOTS_PER_WORD-1:0];
		end else if (pop && !cur.is_ptr && cmd == LBD_C_INC && opt_blink_r && in_arb(ptr_r)) begin
			mem_r[arb_idx(ptr_r)] <= '0;
		end
	end

	// Display and character blink stores live outside; they get a pulse and address
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_display_r <= 1'b0;
			clear_char_blink_r <= 1'b0;
			clear_addr_r <= LBD_PTR_RST;
		end else if (ce_i) begin
			clear_display_r <= pop & ~cur.is_ptr & (cmd == LBD_C_INC) & opt_disp_r;
			clear_char_blink_r <= pop & ~cur.is_ptr & (cmd == LBD_C_INC) & opt_blink_r;
			if (pop && !cur.is_ptr && cmd == LBD_C_INC) begin
				clear_addr_r <= ptr_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;
	assign pattern_o = pattern_r;
	assign clear_display_o = clear_display_r;
	assign clear_char_blink_o = clear_char_blink_r;
	assign clear_addr_o = clear_addr_r;
	for (genvar g = 0; g < LBD_BLINK_WORDS; g++) begin : g_dots
		assign blink_dots_o[g*LBD_DOTS_PER_WORD +: LBD_DOTS_PER_WORD] = mem_r[g];
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic ex;
	assign ex = pop & ~cur.is_ptr;

	property p_arm;
		ex && cmd == LBD_C_ARM && cur.data[0] && unit_r |=> armed_r;
	endproperty
	a_arm: assert property (p_arm) else $error("arm command did not arm");

	property p_no_arm_five;
		ex && cmd == LBD_C_ARM && !unit_r |=> !armed_r;
	endproperty
	a_no_arm_five: assert property (p_no_arm_five) else $error("armed in five-dot unit");

	property p_store;
		data_store |=> mem_r[arb_idx($past(ptr_r))] == $past(cur.data[4:0]);
	endproperty
	a_store: assert property (p_store) else $error("blink data not stored");

	property p_step;
		data_store |=> ptr_r == 5'($past(ptr_r) + LBD_PTR_STEP);
	endproperty
	a_step: assert property (p_step) else $error("pointer did not advance");

	property p_end_drop;
		ex && cmd == LBD_C_DATA && ptr_r == LBD_ARB_END |=> ptr_r == LBD_ARB_END && $stable(blink_dots_o);
	endproperty
	a_end_drop: assert property (p_end_drop) else $error("data at end changed state");

	property p_pattern;
		ex && cmd == LBD_C_PATTERN |=> pattern_o == $past(cur.data[0]) && $stable(ptr_r);
	endproperty
	a_pattern: assert property (p_pattern) else $error("pattern not taken");

	property p_inc;
		ex && cmd == LBD_C_INC |=> ptr_r == 5'($past(ptr_r) + LBD_PTR_STEP);
	endproperty
	a_inc: assert property (p_inc) else $error("increment failed");

	property p_clear_disp;
		ex && cmd == LBD_C_INC && opt_disp_r |=> clear_display_o && clear_addr_o == $past(ptr_r);
	endproperty
	a_clear_disp: assert property (p_clear_disp) else $error("clear pulse wrong");

	// Back-to-back increments or enable low may keep the pulse up; otherwise it lasts one cycle
	property p_disp_pulse;
		clear_display_o && ce_i && !(ex && cmd == LBD_C_INC && opt_disp_r) |=> !clear_display_o;
	endproperty
	a_disp_pulse: assert property (p_disp_pulse) else $error("clear pulse too long");

	property p_clear_blink;
		ex && cmd == LBD_C_INC && opt_blink_r && in_arb(ptr_r) |=> mem_r[arb_idx($past(ptr_r))] == '0;
	endproperty
	a_clear_blink: assert property (p_clear_blink) else $error("blink entry not cleared");

	property p_full_wait;
		ce_i && avs_write_i && is_queued && !fifo_in_ready |=> avs_waitrequest_o;
	endproperty
	a_full_wait: assert property (p_full_wait) else $error("write taken while full");

	c_store: cover property (data_store ##[1:20] data_store);
	c_end: cover property (ex && cmd == LBD_C_DATA && ptr_r == LBD_ARB_END);
	c_full: cover property (fifo_count == CW'(LBD_FIFO_DEPTH));
	c_clear: cover property (clear_display_o && clear_char_blink_o);

endmodule : lbd_decoder

/* verif/lbd_host_model.sv */
`timescale 1ns/1ps
module lbd_host_model
	import lbd_pkg::*;
(
	input wire logic clk_i,
	input wire logic waitrequest_i,
	input wire logic [31:0] readdata_i,
	output logic [7:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [31:0] writedata_o,
	output logic [3:0] byteenable_o
);
	initial begin
		address_o = 8'h00;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h0000_0000;
		byteenable_o = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus cycles; the wait is unbounded, the bench watchdog cuts hangs
	task bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_i);
		address_o <= a;
		writedata_o <= d;
		byteenable_o <= be;
		write_o <= 1'b1;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		write_o <= 1'b0;
		// Released data inverted so a stale value never passes
		writedata_o <= ~d;
	endtask : bus_write

	task bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		address_o <= a;
		read_o <= 1'b1;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		d = readdata_i;
		read_o <= 1'b0;
	endtask : bus_read

	////////////////////////////////////////////////////////////////////////
	// Serial words, command/data select carried in bit 8
	task send_cmd(input logic [7:0] c);
		bus_write(LBD_OFS_CMD, {23'h0, 1'b1, c}, 4'hF);
	endtask : send_cmd

	task send_data(input logic [7:0] c);
		bus_write(LBD_OFS_CMD, {23'h0, 1'b0, c}, 4'hF);
	endtask : send_data

	task start_dot_write(input logic [4:0] p);
		bus_write(LBD_OFS_PTR, {27'h0, p}, 4'hF);
		send_cmd(8'h9D);
		send_cmd(8'h8D);
	endtask : start_dot_write
endmodule : lbd_host_model

/* verif/test_lcd_blink_command_decoder.sv */
`timescale 1ns/1ps
module test_lcd_blink_command_decoder
	import lbd_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_n_i;
	logic ce = 1'b1;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic pattern_o;
	logic [64:0] blink_dots_o;
	logic clear_display_o;
	logic clear_char_blink_o;
	logic [4:0] clear_addr_o;
	int num_errors = 0;
	int n_checks = 0;
	int n_disp = 0;
	int n_chb = 0;
	int ed = 0;
	int ec = 0;
	logic [64:0] exp_dots = '0;
	logic [31:0] rd;
	logic [7:0] pat [4] = '{8'h83, 8'h82, 8'h93, 8'h92};
	logic [7:0] opt [4] = '{8'hB2, 8'hB1, 8'hB3, 8'hB0};
	logic [7:0] inc [4] = '{8'h8A, 8'h8E, 8'h9B, 8'h8A};

	always #5 clk_i = ~clk_i;

	lbd_decoder lbd_decoder_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
		.avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
		.avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
		.pattern_o(pattern_o), .blink_dots_o(blink_dots_o),
		.clear_display_o(clear_display_o), .clear_char_blink_o(clear_char_blink_o),
		.clear_addr_o(clear_addr_o));

	lbd_host_model lbd_host_model_inst (.clk_i(clk_i), .waitrequest_i(avs_waitrequest),
		.readdata_i(avs_readdata), .address_o(avs_address), .read_o(avs_read),
		.write_o(avs_write), .writedata_o(avs_writedata), .byteenable_o(avs_byteenable));

	// Pulses last one cycle, so count them at every edge
	always @(posedge clk_i) begin
		if (clear_display_o === 1'b1) n_disp++;
		if (clear_char_blink_o === 1'b1) n_chb++;
	end

	////////////////////////////////////////////////////////////////////////
	// Reporting and compares
	task complete_run;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check_word

	task check_dots;
		n_checks++;
		if (blink_dots_o !== exp_dots) begin
			num_errors++;
			$display("mismatch at %0t: dots got %h exp %h", $time, blink_dots_o, exp_dots);
		end
	endtask : check_dots

	task check_reg(input logic [7:0] a, input logic [31:0] exp);
		lbd_host_model_inst.bus_read(a, rd);
		check_word(rd, exp, "register");
	endtask : check_reg

	task check_all;
		check_dots;
		for (int i = 0; i < 13; i++) check_reg(8'h40 + 8'(4 * i), {27'h0, exp_dots[5*i+:5]});
	endtask : check_all

	initial begin
		#300000;
		num_errors++;
		complete_run;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		check_reg(LBD_OFS_STATUS, 32'h0);
		check_reg(LBD_OFS_PTR, 32'h0);
		check_word({31'h0, pattern_o}, 32'h0, "pattern");
		check_dots;
		lbd_host_model_inst.start_dot_write(LBD_ARB_FIRST);
		check_reg(LBD_OFS_STATUS, 32'h3);
		// Last word lands at the end pointer and must be dropped
		for (int i = 0; i < 14; i++) begin
			lbd_host_model_inst.send_data({3'b111, 5'(i + 3)});
			if (i < 13) exp_dots[5*i+:5] = 5'(i + 3);
			check_reg(LBD_OFS_PTR, {27'h0, (i < 13) ? 5'(17 + i) : LBD_ARB_END});
		end
		check_all;
		lbd_host_model_inst.send_cmd(8'h9C);
		lbd_host_model_inst.send_cmd(8'h8D);
		check_reg(LBD_OFS_STATUS, 32'h0);
		lbd_host_model_inst.bus_write(LBD_OFS_PTR, {27'h0, LBD_ARB_FIRST}, 4'hF);
		lbd_host_model_inst.send_data(8'h1F);
		check_reg(LBD_OFS_PTR, 32'h10);
		check_dots;
		for (int i = 0; i < 4; i++) begin
			lbd_host_model_inst.send_cmd(pat[i]);
			check_reg(LBD_OFS_PTR, 32'h10);
			check_word({31'h0, pattern_o}, {31'h0, pat[i][0]}, "pattern");
		end
		for (int i = 0; i < 4; i++) begin
			lbd_host_model_inst.send_cmd(opt[i]);
			lbd_host_model_inst.bus_write(LBD_OFS_PTR, 32'(18 + 2 * i), 4'hF);
			lbd_host_model_inst.send_cmd(inc[i]);
			if (opt[i][1]) exp_dots[5*(2+2*i)+:5] = 5'h00;
			if (opt[i][1]) ec++;
			if (opt[i][0]) ed++;
			check_reg(LBD_OFS_PTR, 32'(19 + 2 * i));
			check_word(32'(clear_addr_o), 32'(18 + 2 * i), "clear address");
			check_word(32'(n_chb), 32'(ec), "blink clears");
			check_word(32'(n_disp), 32'(ed), "display clears");
		end
		check_all;
		// Hold stops draining so the FIFO can be seen full
		lbd_host_model_inst.bus_write(LBD_OFS_CTRL, 32'h1, 4'hF);
		for (int i = 0; i < 4; i++) lbd_host_model_inst.send_cmd(i[0] ? 8'h83 : 8'h82);
		check_reg(LBD_OFS_STATUS, 32'h420);
		check_reg(LBD_OFS_CTRL, 32'h1);
		lbd_host_model_inst.bus_write(LBD_OFS_CTRL, 32'h0, 4'hF);
		// Enable low must stop the drain with three entries still queued
		ce <= 1'b0;
		repeat (5) @(posedge clk_i);
		check_word({31'h0, pattern_o}, 32'h0, "frozen pattern");
		ce <= 1'b1;
		repeat (6) @(posedge clk_i);
		check_reg(LBD_OFS_STATUS, 32'h4);
		lbd_host_model_inst.bus_write(8'h20, 32'hFFFF_FFFF, 4'hF);
		check_reg(8'h20, 32'h0);
		check_reg(LBD_OFS_CMD, 32'h0);
		lbd_host_model_inst.bus_write(LBD_OFS_CMD, {23'h0, 1'b1, 8'h82}, 4'hE);
		check_reg(LBD_OFS_STATUS, 32'h4);
		check_word({31'h0, pattern_o}, 32'h1, "pattern");
		complete_run;
	end
endmodule : test_lcd_blink_command_decoder
